//--- bench/pir_periph_model.sv
// behavioural peripheral interfaces on the party-line bus
`timescale 1ns/1ps
module pir_periph_model #(
  parameter logic [5:0]  DEV_BASE = 6'h10,
  parameter logic [15:0] VEC_LOC  = 16'h0100
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire pir_pkg::pir_io_t           io,
  input  wire logic [pir_pkg::NLINE-1:0]  evt,
  input  wire logic                       slow,
  input  wire logic [pir_pkg::NLINE-1:0]  lineAck,
  output logic      [pir_pkg::NLINE-1:0]  reqOut,
  output logic      [15:0]                vectorOut
);
  logic [pir_pkg::NLINE-1:0] mask_r, pend_r, dly_r;
  logic                      hit;
  logic [5:0]                sub;
  // addresses start above 8, so 0 and 8 are never decoded
  assign sub = io.devAddr - DEV_BASE;
  assign hit = io.valid && io.select && sub < 6'h07;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= '0;
      pend_r <= '0;
      dly_r  <= '0;
    end else begin
      if (hit) mask_r[sub[2:0]] <= (io.func == 5'h00);
      pend_r <= (pend_r | (evt & mask_r)) & ~lineAck;
      dly_r  <= pend_r & ~lineAck;
    end
  end
  // slow mode raises a cycle late but still drops on ack
  assign reqOut = slow ? (dly_r & pend_r) : pend_r;
  // released vector lines show the inverse, never the last value
  assign vectorOut = pend_r[pir_pkg::LINEV] ? VEC_LOC : ~VEC_LOC;
endmodule : pir_periph_model

//--- bench/pir_recognizer_properties.sv
// port assertions for the interrupt recognition block
`timescale 1ns/1ps
module pir_recognizer_checker (
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire pir_pkg::pir_core_t         core,
  input wire pir_pkg::pir_io_t           io,
  input wire logic                       intFetch,
  input wire logic [15:0]                intLoc,
  input wire logic                       resumeValid,
  input wire logic                       resumeUseNew,
  input wire logic [15:0]                resumePc,
  input wire logic [pir_pkg::NLINE-1:0]  lineAck,
  input wire logic                       internalSel,
  input wire logic                       senseTrue,
  input wire logic                       rtcEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****************
  // service steps
  // ****************
  sequence s_done(logic w);
    intFetch && core.intDone && core.pcWritten == w;
  endsequence
  sequence s_cmd(logic s, logic [5:0] d);
    io.valid && io.sense == s && io.select == !s && io.devAddr == d;
  endsequence
  a_ack_at_boundary : assert property
    (|lineAck |-> $past(core.instrEnd) && !$past(core.halted))
    else $error("ack without boundary");
  a_halt_blocks : assert property
    (core.halted |=> lineAck == '0) else $error("ack while halted");
  a_ack_onehot : assert property
    (|lineAck |-> $onehot(lineAck) && intFetch) else $error("ack not one-hot");
  a_one_instr : assert property
    (intFetch && $past(intFetch) |-> lineAck == '0)
    else $error("second ack in service");
  for (genvar g = 0; g < pir_pkg::NLINE - 1; g++) begin : g_loc
    a_fixed_loc : assert property
      (lineAck[g] |-> intLoc == pir_pkg::FIX_LOC[g]) else $error("bad loc");
  end
  a_resume_new : assert property
    (s_done(1'b1) |=> resumeValid && resumeUseNew && !intFetch
      && resumePc == $past(core.pc)) else $error("bad jump resume");
  a_resume_seq : assert property
    (s_done(1'b0) |=> resumeValid && !resumeUseNew && !intFetch)
    else $error("bad sequential resume");
  a_dev_reserved : assert property
    (internalSel == (io.valid && (io.devAddr == pir_pkg::DEV_INT0
      || io.devAddr == pir_pkg::DEV_INT8))) else $error("bad internal sel");
  a_sense_opt : assert property
    (s_cmd(1'b1, pir_pkg::DEV_INT0) ##0 (io.func < 5'h05) |=> senseTrue)
    else $error("option not sensed");
  a_rtc_on : assert property
    (s_cmd(1'b0, pir_pkg::DEV_INT8) ##0 (io.func == pir_pkg::FN_RTC_ON)
      |=> rtcEnable) else $error("clock not enabled");
endmodule : pir_recognizer_checker
bind pir_recognizer pir_recognizer_checker i_pir_recognizer_checker (
  .clk, .rst_b, .core, .io, .intFetch, .intLoc, .resumeValid, .resumeUseNew,
  .resumePc, .lineAck, .internalSel, .senseTrue, .rtcEnable);

//--- bench/pir_recognizer_test.sv
// self-checking bench for the interrupt recognition block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errTotal++; \
  $display("wrong value at %0t: %h %h", $time, a, e); end end
module pir_recognizer_test;
  localparam logic [5:0]  DEVB = 6'h10;
  localparam logic [15:0] VEC  = 16'h0100;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [31:0]        haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic               hready, hresp, stopSwitch = 1'b0, slow = 1'b0;
  pir_pkg::pir_core_t core = '0;
  pir_pkg::pir_io_t   io = '0;
  logic [6:0]         evt = 7'h00, req, lineAck, expMask = 7'h7F;
  logic [15:0]        vec, intLoc, resumePc;
  logic intFetch, resumeValid, resumeUseNew, internalSel, senseTrue;
  logic rtcEnable, memMapRam, irq;
  logic [31:0]        seed = 32'h0000022C;
  int                 errTotal = 0, comparisons = 0, cyc = 0, expPend = 0;
  bit                 expEna = 0, hold = 0;
  always #12.5 clk = ~clk;
  pir_recognizer i_pir_recognizer (.clk, .rst_b, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp,
    .hrdata, .fixedIrqLineOne(req[4]), .fixedIrqLineTwo(req[5]),
    .vectoredIrqLine(req[6]), .optIrqLine(req[3:0]), .vectorIn(vec),
    .stopSwitch, .core, .io, .intFetch, .intLoc, .resumeValid, .resumeUseNew,
    .resumePc, .lineAck, .internalSel, .senseTrue, .rtcEnable, .memMapRam,
    .irq);
  pir_periph_model #(.DEV_BASE(DEVB), .VEC_LOC(VEC)) i_pir_periph_model (
    .clk, .rst_b, .io, .evt, .slow, .lineAck, .reqOut(req), .vectorOut(vec));
  // ****************
  // bus and model
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int pick();
    if (!expEna || hold) return -1;
    for (int i = 0; i < 7; i++) if (expPend[i]) return i;
    return -1;
  endfunction : pick
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= pir_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    `CHK(d, e)
    `CHK(hresp, 1'b0)
  endtask : rdChk
  task automatic ioCmd(input logic s, input logic [5:0] d,
                       input logic [4:0] f, input logic es);
    io <= '{1'b1, s, !s, d, f};
    @(negedge clk);
    `CHK(internalSel, d == 6'h00 || d == 6'h08)
    @(posedge clk);
    io.valid <= 1'b0;
    @(negedge clk);
    `CHK(senseTrue, es)
    @(posedge clk);
  endtask : ioCmd
  task automatic raise(input logic [6:0] m);
    evt <= m;
    @(posedge clk);
    evt <= 7'h00;
    repeat (4) @(posedge clk);
    expPend |= m & expMask;
  endtask : raise
  task automatic serve(input bit jst);
    int ln;
    logic [15:0] sp, np;
    ln = pick();
    sp = rnd();
    np = rnd();
    core.instrEnd <= 1'b1;
    core.pc <= sp;
    @(posedge clk);
    core.instrEnd <= 1'b0;
    @(negedge clk);
    `CHK(lineAck, ln < 0 ? 7'h00 : 7'h01 << ln)
    if (ln >= 0) begin
      `CHK(intLoc, ln == 6 ? VEC : pir_pkg::FIX_LOC[ln])
      `CHK(intFetch, 1'b1)
      expPend &= ~(1 << ln);
      repeat (2) @(posedge clk);
      core <= '{1'b0, 1'b0, 1'b1, np[0], jst, 1'b0, 1'b0, np};
      @(posedge clk);
      core.intDone <= 1'b0;
      @(negedge clk);
      `CHK(resumePc, np[0] ? np : sp)
      `CHK({resumeValid, resumeUseNew, intFetch}, {1'b1, np[0], 1'b0})
      if (jst) expEna = 0;
    end
    repeat (3) @(posedge clk);
  endtask : serve
  task automatic wrapUp;
    if (errTotal == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrapUp
  // ****************
  // scenarios
  // ****************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      wrapUp();
    end
  end
  initial begin
    logic [1:0] e;
    e = 2'b00;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdChk(pir_pkg::OFF_CTRL, 32'h0);
    rdChk(8'h40, 32'h0);
    for (int i = 0; i < 7; i++) ioCmd(1'b0, DEVB + 6'(i), 5'h00, 1'b0);
    ioCmd(1'b0, DEVB + 6'h05, 5'h01, 1'b0);
    expMask = 7'h5F;
    raise(7'h30);
    serve(0);
    wr(pir_pkg::OFF_CTRL, 32'h1);
    wr(pir_pkg::OFF_EVEN, 32'h1);
    expEna = 1;
    rdChk(pir_pkg::OFF_CTRL, 32'h1);
    // disable and enable together: disable must win
    wr(pir_pkg::OFF_CTRL, 32'h3);
    rdChk(pir_pkg::OFF_CTRL, 32'h0);
    wr(pir_pkg::OFF_CTRL, 32'h1);
    rdChk(pir_pkg::OFF_OPTS, 32'h1F);
    serve(0);
    serve(0);
    // bit2 stays from the boundary taken while the enable flag was clear
    rdChk(pir_pkg::OFF_EVSTAT, 32'h5);
    `CHK(irq, 1'b1)
    wr(pir_pkg::OFF_EVCLR, 32'h1);
    @(negedge clk);
    `CHK(irq, 1'b0)
    @(posedge clk);
    ioCmd(1'b0, DEVB + 6'h05, 5'h00, 1'b0);
    expMask = 7'h7F;
    // random mixes force the priority order, one forced line per round
    for (int r = 0; r < 7; r++) begin
      slow <= seed[3];
      raise(7'(rnd()) | 7'(1 << r));
      while (pick() >= 0) serve(0);
    end
    raise(7'h01);
    serve(1);
    rdChk(pir_pkg::OFF_CTRL, 32'h0);
    raise(7'h02);
    serve(0);
    core.einExec <= 1'b1;
    @(posedge clk);
    core.einExec <= 1'b0;
    expEna = 1;
    @(posedge clk);
    hold = 1;
    stopSwitch <= 1'b1;
    repeat (3) @(posedge clk);
    serve(0);
    stopSwitch <= 1'b0;
    core.halted <= 1'b1;
    repeat (3) @(posedge clk);
    serve(0);
    core.halted <= 1'b0;
    hold = 0;
    @(posedge clk);
    serve(0);
    for (int f = 0; f < 6; f++) ioCmd(1'b1, 6'h00, 5'(f), f < 5);
    for (int f = 0; f < 4; f++) begin
      ioCmd(1'b0, 6'h08, 5'(f), 1'b0);
      e[1 - f / 2] = (f % 2 == 0);
      `CHK({rtcEnable, memMapRam}, e)
    end
    wrapUp();
  end
endmodule : pir_recognizer_test

//--- hdl/pir_prio.sv
// fixed priority picker over the pending request lines
`timescale 1ns/1ps
module pir_prio (
  input  wire logic [pir_pkg::NLINE-1:0] req,
  output logic      [pir_pkg::NLINE-1:0] grant,
  output logic      [pir_pkg::IDXW-1:0]  idx,
  output logic                           any
);

  logic [pir_pkg::NLINE:0] above;

  assign above[0] = 1'b0;

  // ****************************************************************
  // lower index wins; a line waits while anything above it pends
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < pir_pkg::NLINE; i++) begin : g_line
      assign grant[i]   = req[i] & ~above[i]; // R10
      assign above[i+1] = above[i] | req[i];
    end
  endgenerate

  assign any = above[pir_pkg::NLINE];

  always_comb begin
    idx = '0;
    for (int k = pir_pkg::NLINE - 1; k >= 0; k--) begin
      if (req[k]) begin
        idx = k[pir_pkg::IDXW-1:0];
      end
    end
  end

endmodule : pir_prio

//--- hdl/pir_recognizer.sv
// interrupt recognition, resume control and internal device addresses
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module pir_recognizer (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  input  wire logic                          fixedIrqLineOne,
  input  wire logic                          fixedIrqLineTwo,
  input  wire logic                          vectoredIrqLine,
  input  wire logic [pir_pkg::NOPT-1:0]      optIrqLine,
  input  wire logic [15:0]                   vectorIn,
  input  wire logic                          stopSwitch,
  input  wire pir_pkg::pir_core_t            core,
  input  wire pir_pkg::pir_io_t              io,
  output logic                               intFetch,
  output logic      [15:0]                   intLoc,
  output logic                               resumeValid,
  output logic                               resumeUseNew,
  output logic      [15:0]                   resumePc,
  output logic      [pir_pkg::NLINE-1:0]     lineAck,
  output logic                               internalSel,
  output logic                               senseTrue,
  output logic                               rtcEnable,
  output logic                               memMapRam,
  output logic                               irq
);

  localparam int SYNW = pir_pkg::NLINE + 17;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [SYNW-1:0] syn1_r;
  logic [SYNW-1:0] syn2_r;
  logic [SYNW-1:0] pinAll;

  assign pinAll = {stopSwitch, vectorIn, vectoredIrqLine,
                   fixedIrqLineTwo, fixedIrqLineOne, optIrqLine};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syn1_r <= '0;
      syn2_r <= '0;
    end else begin
      syn1_r <= pinAll;
      syn2_r <= syn1_r;
    end
  end

  logic [pir_pkg::NLINE-1:0] pend;
  logic [15:0]               vecSync;
  logic                      stopSync;

  // options occupy the low, highest priority slots
  assign pend     = syn2_r[pir_pkg::NLINE-1:0]; // R6 R5
  assign vecSync  = syn2_r[pir_pkg::NLINE+15:pir_pkg::NLINE];
  assign stopSync = syn2_r[SYNW-1];

  // ****************************************************************
  // priority selection
  // ****************************************************************
  logic [pir_pkg::NLINE-1:0] grant;
  logic [pir_pkg::IDXW-1:0]  winIdx;
  logic                      anyPend;

  pir_prio u_prio (
    .req   (pend),
    .grant (grant),
    .idx   (winIdx),
    .any   (anyPend)
  );

  logic [15:0] winLoc;

  // vector comes from the requesting interface, others are fixed
  assign winLoc = (winIdx == pir_pkg::IDXW'(pir_pkg::LINEV))
                  ? vecSync                          // R5
                  : pir_pkg::FIX_LOC[winIdx];        // R4

  // ****************************************************************
  // bus address phase and decode
  // ****************************************************************
  logic       aPhase;
  logic       dWr_r;
  logic [7:0] dOff_r;
  logic [7:0] aOff;

  assign aPhase = hsel & hready & htrans[1];
  assign aOff   = {haddr[7:2], 2'b00};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dWr_r  <= 1'b0;
      dOff_r <= '0;
    end else begin
      dWr_r  <= aPhase & hwrite;
      dOff_r <= aOff;
    end
  end

  // only whole words are used; hsize is accepted and ignored
  logic wrCtrl;
  logic wrEvClr;
  logic wrEvEn;

  assign wrCtrl  = dWr_r & (dOff_r == pir_pkg::OFF_CTRL);
  assign wrEvClr = dWr_r & (dOff_r == pir_pkg::OFF_EVCLR);
  assign wrEvEn  = dWr_r & (dOff_r == pir_pkg::OFF_EVEN);

  // ****************************************************************
  // recognition conditions
  // ****************************************************************
  pir_pkg::pir_state_t state_r;
  pir_pkg::pir_state_t state_nxt;
  logic                enable_r;
  logic                runMode;
  logic                atEdge;
  logic                recog;

  assign runMode = ~core.halted & ~stopSync;          // R11
  assign atEdge  = core.instrEnd & (state_r == pir_pkg::ST_RUN); // R12
  assign recog   = atEdge & enable_r & runMode & anyPend; // R7 R11 R12

  logic serveEnd;
  logic jstOff;
  logic swEna;
  logic swDis;

  assign serveEnd = (state_r == pir_pkg::ST_SERVE) & core.intDone;
  assign jstOff   = serveEnd & core.intIsJst;         // R18
  assign swEna    = wrCtrl & hwdata[pir_pkg::CTL_ENA];
  assign swDis    = wrCtrl & hwdata[pir_pkg::CTL_DIS];

  // ****************************************************************
  // sequence: run, serve one instruction, hand back the pc
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pir_pkg::ST_RUN: begin
        if (recog) begin
          state_nxt = pir_pkg::ST_SERVE;
        end
      end
      pir_pkg::ST_SERVE: begin
        if (core.intDone) begin
          state_nxt = pir_pkg::ST_BACK;               // R1
        end
      end
      pir_pkg::ST_BACK: begin
        state_nxt = pir_pkg::ST_RUN;
      end
      default: begin
        state_nxt = pir_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= pir_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // disabling conditions win over a same-cycle enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_r <= 1'b0;
    end else if (jstOff | core.disExec | swDis) begin
      enable_r <= 1'b0;                               // R18
    end else if (core.einExec | swEna) begin
      enable_r <= 1'b1;                               // R7
    end
  end

  // ****************************************************************
  // fetch redirection and resume
  // ****************************************************************
  logic        intFetch_r;
  logic [15:0] intLoc_r;
  logic [15:0] savedPc_r;
  logic        resumeValid_r;
  logic        resumeUseNew_r;
  logic [15:0] resumePc_r;
  logic [pir_pkg::NLINE-1:0] lineAck_r;

  // the core has not advanced p, so core.pc is the next main address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intFetch_r <= 1'b0;
      intLoc_r   <= '0;
      savedPc_r  <= '0;
      lineAck_r  <= '0;
    end else begin
      lineAck_r <= recog ? grant : '0;              // R19
      if (recog) begin
        intFetch_r <= 1'b1;                           // R1 R13
        intLoc_r   <= winLoc;
        savedPc_r  <= core.pc;
      end else if (serveEnd) begin
        intFetch_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resumeValid_r  <= 1'b0;
      resumeUseNew_r <= 1'b0;
      resumePc_r     <= '0;
    end else begin
      resumeValid_r <= serveEnd;
      if (serveEnd) begin
        resumeUseNew_r <= core.pcWritten;
        resumePc_r     <= core.pcWritten ? core.pc   // R3
                                         : savedPc_r; // R2
      end
    end
  end

  assign intFetch     = intFetch_r;
  assign intLoc       = intLoc_r;
  assign resumeValid  = resumeValid_r;
  assign resumeUseNew = resumeUseNew_r;
  assign resumePc     = resumePc_r;
  assign lineAck      = lineAck_r;

  // ****************************************************************
  // reserved internal device addresses
  // ****************************************************************
  logic hitDev0;
  logic hitDev8;

  assign hitDev0 = io.valid & (io.devAddr == pir_pkg::DEV_INT0);
  assign hitDev8 = io.valid & (io.devAddr == pir_pkg::DEV_INT8);

  // tells the bus logic that no outside interface may answer
  assign internalSel = hitDev0 | hitDev8;             // R14

  logic senseTrue_r;
  logic rtcEnable_r;
  logic memMapRam_r;
  logic senseHit;

  // unknown function codes sense as absent
  assign senseHit = (io.func < 5'(pir_pkg::NSENSE))
                    & pir_pkg::OPT_PRESENT[io.func[2:0]];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      senseTrue_r <= 1'b0;
    end else begin
      senseTrue_r <= hitDev0 & io.sense & senseHit;  // R15
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rtcEnable_r <= 1'b0;
      memMapRam_r <= 1'b0;
    end else if (hitDev8 & io.select) begin
      case (io.func)
        pir_pkg::FN_RTC_ON:  rtcEnable_r <= 1'b1;     // R16
        pir_pkg::FN_RTC_OFF: rtcEnable_r <= 1'b0;     // R16
        pir_pkg::FN_MAP_RAM: memMapRam_r <= 1'b1;     // R16
        pir_pkg::FN_MAP_ROM: memMapRam_r <= 1'b0;     // R16
        default: begin
          rtcEnable_r <= rtcEnable_r;
        end
      endcase
    end
  end

  assign senseTrue = senseTrue_r;
  assign rtcEnable = rtcEnable_r;
  assign memMapRam = memMapRam_r;

  // ****************************************************************
  // event status, enable and interrupt output
  // ****************************************************************
  logic [pir_pkg::NEVT-1:0] evSet;
  logic [pir_pkg::NEVT-1:0] evStat_r;
  logic [pir_pkg::NEVT-1:0] evEn_r;
  logic [pir_pkg::NEVT-1:0] evClr;

  assign evSet[pir_pkg::EV_RECOG]  = recog;
  assign evSet[pir_pkg::EV_JSTOFF] = jstOff;
  assign evSet[pir_pkg::EV_HELD]   = atEdge & anyPend & ~recog;
  assign evClr = wrEvClr ? hwdata[pir_pkg::NEVT-1:0] : '0;

  // a set in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evStat_r <= '0;
      evEn_r   <= '0;
    end else begin
      evStat_r <= (evStat_r & ~evClr) | evSet;
      if (wrEvEn) begin
        evEn_r <= hwdata[pir_pkg::NEVT-1:0];
      end
    end
  end

  assign irq = |(evStat_r & evEn_r);

  // ****************************************************************
  // read data, registered so it stands through the data phase
  // ****************************************************************
  logic [31:0] rdSel;
  logic [31:0] hrdata_r;

  always_comb begin
    rdSel = '0;
    case (aOff)
      pir_pkg::OFF_CTRL:   rdSel = {31'h0, enable_r};
      pir_pkg::OFF_STATE:  rdSel = {8'h00, 5'h00, memMapRam_r,
                                    rtcEnable_r, stopSync,
                                    pend, 6'h00, state_r};
      pir_pkg::OFF_OPTS:   rdSel = {27'h0, pir_pkg::OPT_PRESENT};
      pir_pkg::OFF_EVSTAT: rdSel = {29'h0, evStat_r};
      pir_pkg::OFF_EVEN:   rdSel = {29'h0, evEn_r};
      pir_pkg::OFF_SAVEPC: rdSel = {16'h0, savedPc_r};
      default:             rdSel = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_r <= '0;
    end else if (aPhase & ~hwrite) begin
      hrdata_r <= rdSel;
    end
  end

  // zero wait states, always OKAY
  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : pir_recognizer

//--- inc/pir_pkg.sv
// constants and carrier types for the priority interrupt recognition block
// ****************************************************************
// Operation
// R1 - an accepted interrupt runs exactly one instruction from its location
// R2 - pc untouched by that instruction: resume at next sequential address
// R3 - pc altered by that instruction: continue fetching from new pc
// R4 - interrupt locations are fixed in hardware, never moved by software
// R5 - two fixed-location lines plus one vectored line, vector from device
// R6 - processor options get dedicated request lines of their own
// R7 - global enable set by enable instruction; while clear, nothing taken
// R8 - interfaces keep per-interrupt masks, set and cleared by select
// R9 - interfaces raise requests only after the enabled event occurred
// R10 - fixed priorities; highest pending served, lower ones wait
// R11 - no recognition while halted or stop switch down; run mode only
// R12 - recognition only at instruction end, then highest pending request
// R13 - nearly any instruction may serve as the interrupt instruction
// R14 - device addresses 0 and 8 belong to the processor alone
// R15 - sense on device 0 reports which options are installed
// R16 - device 8 controls clock option and two control instructions
// R17 - only the interface matching the device address responds
// R18 - jump-and-store run as interrupt instruction clears global enable
// R19 - interfaces hold requests until the processor recognizes them
// ****************************************************************
package pir_pkg;

  localparam int NOPT  = 4;
  localparam int NLINE = NOPT + 3;
  localparam int IDXW  = 3;
  localparam int LINE1 = NOPT;
  localparam int LINE2 = NOPT + 1;
  localparam int LINEV = NOPT + 2;
  localparam int NSENSE = 5;
  localparam int NEVT  = 3;

  // fixed interrupt locations, index 0 highest priority
  localparam logic [15:0] FIX_LOC [0:NLINE-2] = '{
    16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0002, 16'h0004};

  localparam logic [5:0] DEV_INT0 = 6'h00;
  localparam logic [5:0] DEV_INT8 = 6'h08;

  localparam logic [4:0] FN_RTC_ON  = 5'h00;
  localparam logic [4:0] FN_RTC_OFF = 5'h01;
  localparam logic [4:0] FN_MAP_RAM = 5'h02;
  localparam logic [4:0] FN_MAP_ROM = 5'h03;

  localparam logic [4:0] OPT_PRESENT = 5'h1F;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATE  = 8'h04;
  localparam logic [7:0] OFF_OPTS   = 8'h08;
  localparam logic [7:0] OFF_EVSTAT = 8'h0C;
  localparam logic [7:0] OFF_EVCLR  = 8'h10;
  localparam logic [7:0] OFF_EVEN   = 8'h14;
  localparam logic [7:0] OFF_SAVEPC = 8'h18;

  localparam int CTL_ENA = 0;
  localparam int CTL_DIS = 1;

  localparam int EV_RECOG = 0;
  localparam int EV_JSTOFF = 1;
  localparam int EV_HELD  = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic        instrEnd;
    logic        halted;
    logic        intDone;
    logic        pcWritten;
    logic        intIsJst;
    logic        einExec;
    logic        disExec;
    logic [15:0] pc;
  } pir_core_t;

  typedef struct packed {
    logic       valid;
    logic       sense;
    logic       select;
    logic [5:0] devAddr;
    logic [4:0] func;
  } pir_io_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_SERVE = 3'h2,
    ST_BACK  = 3'h4
  } pir_state_t;

endpackage : pir_pkg
